// File: verilog/dcf_consts.svh
// constants for the dual clock fifo channel
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH
`define DCF_DW          9
`define DCF_AW          8
`define DCF_PW          9
`define DCF_DEPTH       256
`define DCF_DEPTH_CNT   9'h100
`define DCF_PTR_ZERO    9'h000
`define DCF_PTR_ONE     9'h001
`define DCF_OFS_W       8
`define DCF_OFS_MSB     7
`define DCF_NUM_OFS     4
`define DCF_OFS_DEFAULT 8'h07
`define DCF_OFS_ZERO    8'h00
`define DCF_SEL_E_LSB   2'h0
`define DCF_SEL_E_MSB   2'h1
`define DCF_SEL_F_LSB   2'h2
`define DCF_SEL_F_MSB   2'h3
`define DCF_SEL_ONE     2'h1
`define DCF_CNT_PAD     7'h00
`define DCF_RD_PAD      1'h0
`endif

// File: verilog/dcf_pkg.sv
// types for the dual clock fifo channel
`include "dcf_consts.svh"
package dcf_pkg;
  typedef enum logic {
    DCF_MODE_TWO_EN,
    DCF_MODE_LOAD
  } dcf_mode_t;

  typedef struct packed {
    logic [`DCF_DEPTH-1:0][`DCF_DW-1:0]    mem;
    logic                                  wr_clk_q;
    logic                                  rd_clk_q;
    dcf_mode_t                             mode;
    logic [`DCF_PW-1:0]                    wptr;
    logic [`DCF_PW-1:0]                    rptr;
    logic [`DCF_NUM_OFS-1:0][`DCF_OFS_W-1:0] ofs;
    logic [1:0]                            wsel;
    logic [1:0]                            rsel;
    logic [`DCF_DW-1:0]                    rd_data;
    logic                                  oe;
    logic                                  ef_n;
    logic                                  ff_n;
    logic                                  pae_n;
    logic                                  paf_n;
  } dcf_state_t;

  typedef struct packed {
    logic [`DCF_PW-1:0] src;
    logic [`DCF_PW-1:0] s1;
    logic [`DCF_PW-1:0] s2;
  } dcf_sync_t;
endpackage

// File: verilog/dcf_ptr_sync.sv
// gray coded pointer passed through a two stage synchroniser
`timescale 1ns/1ps
`include "dcf_consts.svh"
module dcf_ptr_sync
  import dcf_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               clr_i,
  input  wire logic [`DCF_PW-1:0] bin_i,
  output logic      [`DCF_PW-1:0] bin_o
);
  dcf_sync_t s_q;
  dcf_sync_t s_d;

  always_comb begin
    s_d = s_q;
    if (clr_i) begin
      s_d = '0;
    end else begin
      s_d.src = bin_i ^ (bin_i >> 1);
      s_d.s1  = s_q.src;
      s_d.s2  = s_q.s1;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // gray to binary, each bit is the parity of its own gray bit and the gray bits above it
  genvar i;
  generate
    for (i = 0; i < `DCF_PW; i++) begin : g_bin
      assign bin_o[i] = ^s_q.s2[`DCF_PW-1:i];
    end
  endgenerate
endmodule // dcf_ptr_sync

// File: verilog/dcf_channel.sv
// one fifo channel with write and read sides and four status flags
// Contract
// - channel holds 256 nine-bit words independently
// - reset forces empty, flags valid soon
// - output register zero after reset
// - second enable level at reset picks mode
// - two-enable mode writes when first low, second high
// - load mode writes on first enable low
// - words stored consecutively, independent of reads
// - both read enables low pop next word
// - output enable low drives data outputs
// - writes ignored when full, reads when empty
// - empty keeps last read word on output
// - full release may slip one write edge
// - empty release may slip one read edge
// - almost-empty change may slip one read edge
// - first word latency one or two reads
// - first word readable after empty flag rises
// - full flag blocks writes, write edges only
// - almost-empty low at n or fewer words
// - almost-full low when m or fewer free
// - load strobes fill four offset bytes cyclically
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dcf_consts.svh"
module dcf_channel
  import dcf_pkg::*;
(
  input  wire logic               CORE_CLK_I,
  input  wire logic               SYS_RST_I,
  input  wire logic               FIFO_RST_N_I,
  input  wire logic               WR_CLK_I,
  input  wire logic               WR_EN_FIRST_N_I,
  input  wire logic               WR_EN_SECOND_OR_LOAD_I,
  input  wire logic [`DCF_DW-1:0] WR_DATA_I,
  input  wire logic               RD_CLK_I,
  input  wire logic               RD_EN_FIRST_N_I,
  input  wire logic               RD_EN_SECOND_N_I,
  input  wire logic               OUT_DRIVE_N_I,
  output logic      [`DCF_DW-1:0] RD_DATA_O,
  output logic                    RD_DATA_OE_O,
  output logic                    EMPTY_FLAG_N_O,
  output logic                    FULL_FLAG_N_O,
  output logic                    ALMOST_EMPTY_FLAG_N_O,
  output logic                    ALMOST_FULL_FLAG_N_O
);
  localparam logic [`DCF_NUM_OFS-1:0][`DCF_OFS_W-1:0] OFS_RST =
    {`DCF_OFS_ZERO, `DCF_OFS_DEFAULT, `DCF_OFS_ZERO, `DCF_OFS_DEFAULT};

  dcf_state_t               s_q;
  dcf_state_t               s_d;
  logic                     clr;
  logic                     wr_edge;
  logic                     rd_edge;
  logic                     load_mode;
  logic                     wr_req;
  logic                     rd_req;
  logic                     ofs_wr;
  logic                     ofs_rd;
  logic [`DCF_PW-1:0]       wsync;
  logic [`DCF_PW-1:0]       rsync;
  logic [`DCF_PW-1:0]       wptr_nx;
  logic [`DCF_PW-1:0]       rptr_nx;
  logic [`DCF_PW-1:0]       wcnt;
  logic [`DCF_PW-1:0]       wfree;
  logic [`DCF_PW-1:0]       rcnt;
  logic [`DCF_PW-1:0]       occ;
  logic [2*`DCF_OFS_W-1:0]  n_ofs;
  logic [2*`DCF_OFS_W-1:0]  m_ofs;

  assign clr = SYS_RST_I | ~FIFO_RST_N_I;

  // write pointer towards the read side
  dcf_ptr_sync u_wsync (
    .clk_i (CORE_CLK_I),
    .clr_i (clr),
    .bin_i (s_q.wptr),
    .bin_o (wsync)
  );

  // read pointer towards the write side
  dcf_ptr_sync u_rsync (
    .clk_i (CORE_CLK_I),
    .clr_i (clr),
    .bin_i (s_q.rptr),
    .bin_o (rsync)
  );

  // both pin clocks are sampled on the core clock; a rise marks an edge
  assign wr_edge   = WR_CLK_I & ~s_q.wr_clk_q;
  assign rd_edge   = RD_CLK_I & ~s_q.rd_clk_q;
  assign load_mode = (s_q.mode == DCF_MODE_LOAD);

  // the full flag gates the fifo write in either mode
  assign wr_req = wr_edge & ~WR_EN_FIRST_N_I & WR_EN_SECOND_OR_LOAD_I
                & s_q.ff_n;
  assign ofs_wr = wr_edge & ~WR_EN_FIRST_N_I & ~WR_EN_SECOND_OR_LOAD_I
                & load_mode;
  // the registered empty flag gates pops, so the first word waits one edge
  assign rd_req = rd_edge & ~RD_EN_FIRST_N_I & ~RD_EN_SECOND_N_I
                & s_q.ef_n
                & ~(load_mode & ~WR_EN_SECOND_OR_LOAD_I);
  assign ofs_rd = rd_edge & ~RD_EN_FIRST_N_I & ~RD_EN_SECOND_N_I
                & load_mode & ~WR_EN_SECOND_OR_LOAD_I;

  assign wptr_nx = wr_req ? s_q.wptr + `DCF_PTR_ONE : s_q.wptr;
  assign rptr_nx = rd_req ? s_q.rptr + `DCF_PTR_ONE : s_q.rptr;
  // each side counts against the other side's lagging copy, so a late edge
  // from the far side only shows up one local edge later
  assign wcnt    = wptr_nx - rsync;
  assign wfree   = `DCF_DEPTH_CNT - wcnt;
  assign rcnt    = wsync - rptr_nx;
  assign occ     = s_q.wptr - s_q.rptr;
  assign n_ofs   = {s_q.ofs[`DCF_SEL_E_MSB], s_q.ofs[`DCF_SEL_E_LSB]};
  assign m_ofs   = {s_q.ofs[`DCF_SEL_F_MSB], s_q.ofs[`DCF_SEL_F_LSB]};

  always_comb begin
    s_d          = s_q;
    s_d.wr_clk_q = WR_CLK_I;
    s_d.rd_clk_q = RD_CLK_I;
    s_d.oe       = ~OUT_DRIVE_N_I;
    if (SYS_RST_I) begin
      s_d       = '0;
      s_d.mode  = DCF_MODE_TWO_EN;
      s_d.ofs   = OFS_RST;
      s_d.ff_n  = 1'b1;
      s_d.paf_n = 1'b1;
    end else if (!FIFO_RST_N_I) begin
      // channel reset: empty, defaults, strap captured while held
      s_d.wptr    = `DCF_PTR_ZERO;
      s_d.rptr    = `DCF_PTR_ZERO;
      s_d.ef_n    = 1'b0;
      s_d.pae_n   = 1'b0;
      s_d.ff_n    = 1'b1;
      s_d.paf_n   = 1'b1;
      s_d.rd_data = '0;
      s_d.ofs     = OFS_RST;
      s_d.wsel    = `DCF_SEL_E_LSB;
      s_d.rsel    = `DCF_SEL_E_LSB;
      s_d.mode    = WR_EN_SECOND_OR_LOAD_I ? DCF_MODE_TWO_EN : DCF_MODE_LOAD;
    end else begin
      if (wr_req) begin
        s_d.mem[s_q.wptr[`DCF_AW-1:0]] = WR_DATA_I;
      end
      if (ofs_wr) begin
        s_d.ofs[s_q.wsel] = WR_DATA_I[`DCF_OFS_MSB:0];
        s_d.wsel          = s_q.wsel + `DCF_SEL_ONE;
      end
      if (wr_edge) begin
        s_d.wptr  = wptr_nx;
        s_d.ff_n  = (wcnt != `DCF_DEPTH_CNT);
        s_d.paf_n = ({`DCF_CNT_PAD, wfree} > m_ofs);
      end
      if (rd_req) begin
        s_d.rd_data = s_q.mem[s_q.rptr[`DCF_AW-1:0]];
      end
      if (ofs_rd) begin
        s_d.rd_data = {`DCF_RD_PAD, s_q.ofs[s_q.rsel]};
        s_d.rsel    = s_q.rsel + `DCF_SEL_ONE;
      end
      if (rd_edge) begin
        s_d.rptr  = rptr_nx;
        s_d.ef_n  = (rcnt != `DCF_PTR_ZERO);
        s_d.pae_n = ({`DCF_CNT_PAD, rcnt} > n_ofs);
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    s_q <= s_d;
  end

  assign RD_DATA_O             = s_q.rd_data;
  assign RD_DATA_OE_O          = s_q.oe;
  assign EMPTY_FLAG_N_O        = s_q.ef_n;
  assign FULL_FLAG_N_O         = s_q.ff_n;
  assign ALMOST_EMPTY_FLAG_N_O = s_q.pae_n;
  assign ALMOST_FULL_FLAG_N_O  = s_q.paf_n;

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  AST_NO_OVERRUN: assert property (
    occ <= `DCF_DEPTH_CNT
  ) else $error("unread word count exceeds depth");

  AST_CHAN_RESET: assert property (
    !FIFO_RST_N_I |=> !EMPTY_FLAG_N_O && FULL_FLAG_N_O && !ALMOST_EMPTY_FLAG_N_O
                      && ALMOST_FULL_FLAG_N_O && (RD_DATA_O == '0)
  ) else $error("channel reset did not give empty state");

  AST_MODE_STRAP: assert property (
    !FIFO_RST_N_I |=> s_q.mode == ($past(WR_EN_SECOND_OR_LOAD_I) ? DCF_MODE_TWO_EN
                                                                  : DCF_MODE_LOAD)
  ) else $error("mode not taken from strap during reset");

  AST_WRITE_TWO_EN: assert property (
    FIFO_RST_N_I && wr_edge && !load_mode && !WR_EN_FIRST_N_I && WR_EN_SECOND_OR_LOAD_I
    && s_q.ff_n
    |=> (s_q.wptr == $past(s_q.wptr) + `DCF_PTR_ONE)
        && (s_q.mem[$past(s_q.wptr[`DCF_AW-1:0])] == $past(WR_DATA_I))
  ) else $error("two-enable write not stored");

  AST_WRITE_LOAD_MODE: assert property (
    FIFO_RST_N_I && wr_edge && load_mode && !WR_EN_FIRST_N_I && WR_EN_SECOND_OR_LOAD_I
    && s_q.ff_n |=> s_q.wptr == $past(s_q.wptr) + `DCF_PTR_ONE
  ) else $error("load mode fifo write not stored");

  AST_OFS_LOAD: assert property (
    FIFO_RST_N_I && ofs_wr
    |=> (s_q.ofs[$past(s_q.wsel)] == $past(WR_DATA_I[`DCF_OFS_MSB:0]))
        && (s_q.wsel == $past(s_q.wsel) + `DCF_SEL_ONE) && $stable(s_q.wptr)
  ) else $error("offset byte load wrong");

  AST_FULL_BLOCKS: assert property (
    FIFO_RST_N_I && !s_q.ff_n |=> $stable(s_q.wptr)
  ) else $error("write taken while full");

  AST_WR_SIDE_FLAGS: assert property (
    FIFO_RST_N_I && !wr_edge |=> $stable(FULL_FLAG_N_O) && $stable(ALMOST_FULL_FLAG_N_O)
  ) else $error("write side flag moved without write edge");

  AST_RD_SIDE_FLAGS: assert property (
    FIFO_RST_N_I && !rd_edge |=> $stable(EMPTY_FLAG_N_O) && $stable(ALMOST_EMPTY_FLAG_N_O)
  ) else $error("read side flag moved without read edge");

  AST_POP_DATA: assert property (
    FIFO_RST_N_I && rd_req
    |=> (RD_DATA_O == $past(s_q.mem[s_q.rptr[`DCF_AW-1:0]]))
        && (s_q.rptr == $past(s_q.rptr) + `DCF_PTR_ONE)
  ) else $error("pop did not present next word");

  AST_EMPTY_KEEP: assert property (
    FIFO_RST_N_I && rd_edge && !s_q.ef_n && !ofs_rd |=> $stable(RD_DATA_O)
  ) else $error("output changed while empty");

  AST_OE_FOLLOWS: assert property (
    ##1 (RD_DATA_OE_O == !$past(OUT_DRIVE_N_I))
  ) else $error("output enable does not follow pin");

  sequence s_ef_rise;
    $rose(s_q.ef_n);
  endsequence

  sequence s_no_pop_same_cycle;
    s_q.rptr == $past(s_q.rptr);
  endsequence

  AST_FIRST_WORD_LATER: assert property (
    s_ef_rise |-> s_no_pop_same_cycle
  ) else $error("word popped on the edge that raised empty flag");

  AST_EMPTY_BLOCKS: assert property (
    FIFO_RST_N_I && !s_q.ef_n |=> $stable(s_q.rptr)
  ) else $error("read taken while empty");

  AST_WR_ONLY_ON_EDGE: assert property (
    FIFO_RST_N_I && !wr_edge |=> $stable(s_q.wptr)
  ) else $error("write pointer moved without write edge");

  AST_RD_ONLY_ON_EDGE: assert property (
    FIFO_RST_N_I && !rd_edge |=> $stable(s_q.rptr) && $stable(RD_DATA_O)
  ) else $error("read side moved without read edge");

  AST_MODE_HOLDS: assert property (
    FIFO_RST_N_I |=> $stable(s_q.mode)
  ) else $error("mode changed outside channel reset");

  AST_OFFSETS_HOLD: assert property (
    FIFO_RST_N_I && !ofs_wr |=> $stable(s_q.ofs)
  ) else $error("offset bytes changed without load strobe");

  // flags are registered together, so a full or empty flag implies its partial flag
  AST_FULL_IS_ALMOST: assert property (
    !FULL_FLAG_N_O |-> !ALMOST_FULL_FLAG_N_O
  ) else $error("full flag low while almost-full flag high");

  AST_EMPTY_IS_ALMOST: assert property (
    !EMPTY_FLAG_N_O |-> !ALMOST_EMPTY_FLAG_N_O
  ) else $error("empty flag low while almost-empty flag high");

  AST_SECOND_LOW_NOOP: assert property (
    FIFO_RST_N_I && wr_edge && !load_mode && !WR_EN_SECOND_OR_LOAD_I
    |=> $stable(s_q.wptr) && $stable(s_q.ofs)
  ) else $error("write taken with second enable low");

  AST_OFS_READ: assert property (
    FIFO_RST_N_I && ofs_rd
    |=> (RD_DATA_O == {`DCF_RD_PAD, $past(s_q.ofs[s_q.rsel])})
        && (s_q.rsel == $past(s_q.rsel) + `DCF_SEL_ONE) && $stable(s_q.rptr)
  ) else $error("offset byte read wrong");

  // the pointer copies only mean something once the channel has been out of reset
  sequence s_chan_live;
    FIFO_RST_N_I [*3];
  endsequence

  AST_WPTR_CROSSING: assert property (
    s_chan_live ##1 1'b1 |-> wsync == $past(s_q.wptr, 3)
  ) else $error("write pointer copy lags wrongly");

  AST_RPTR_CROSSING: assert property (
    s_chan_live ##1 1'b1 |-> rsync == $past(s_q.rptr, 3)
  ) else $error("read pointer copy lags wrongly");
endmodule // dcf_channel

// File: tb/dcf_far_end.sv
// far side model: writer, reader and channel reset controller
`timescale 1ns/1ps
`include "dcf_consts.svh"
module dcf_far_end (
  input  wire logic               clk_i,
  output logic                    fifo_rst_n_o,
  output logic                    wr_clk_o,
  output logic                    wr_en_first_n_o,
  output logic                    wr_second_o,
  output logic      [`DCF_DW-1:0] wr_data_o,
  output logic                    rd_clk_o,
  output logic                    rd_en_first_n_o,
  output logic                    rd_en_second_n_o
);
  initial begin
    fifo_rst_n_o = 1'b1;
    wr_clk_o = 1'b0;
    wr_en_first_n_o = 1'b1;
    wr_second_o = 1'b1;
    wr_data_o = 9'h000;
    rd_clk_o = 1'b0;
    rd_en_first_n_o = 1'b1;
    rd_en_second_n_o = 1'b1;
  end

  // pin clocks stand still between transfers; second write enable carries the mode strap during reset
  task chan_reset(input logic lvl);
    @(posedge clk_i);
    fifo_rst_n_o <= 1'b0;
    wr_second_o <= lvl;
    repeat (3) @(posedge clk_i);
    fifo_rst_n_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task push(input logic [`DCF_DW-1:0] d, input logic en1_n, input logic en2);
    @(posedge clk_i);
    wr_clk_o <= 1'b1;
    wr_en_first_n_o <= en1_n;
    wr_second_o <= en2;
    wr_data_o <= d;
    @(posedge clk_i);
    wr_clk_o <= 1'b0;
    wr_en_first_n_o <= 1'b1;
    wr_data_o <= ~d;
    #1;
  endtask

  task pop(input logic en_n);
    pop_split(en_n, en_n);
  endtask

  // read edge with each read enable given on its own
  task pop_split(input logic en1_n, input logic en2_n);
    @(posedge clk_i);
    rd_clk_o <= 1'b1;
    rd_en_first_n_o <= en1_n;
    rd_en_second_n_o <= en2_n;
    @(posedge clk_i);
    rd_clk_o <= 1'b0;
    rd_en_first_n_o <= 1'b1;
    rd_en_second_n_o <= 1'b1;
    #1;
  endtask
endmodule // dcf_far_end

// File: tb/dcf_channel_tb_top.sv
// self-checking bench for the fifo channel
`timescale 1ns/1ps
`include "dcf_consts.svh"
module dcf_channel_tb_top;
  logic               clk;
  logic               sys_rst;
  logic               out_drive_n;
  wire logic          fifo_rst_n;
  wire logic          wr_clk;
  wire logic          wr_en1_n;
  wire logic          wr_second;
  wire logic          rd_clk;
  wire logic          rd_en1_n;
  wire logic          rd_en2_n;
  wire logic [`DCF_DW-1:0] wr_data;
  logic [`DCF_DW-1:0] q;
  logic               q_oe, ef_n, ff_n, pae_n, paf_n;
  logic [`DCF_DW-1:0] ofs [4] = '{9'h002, 9'h000, 9'h003, 9'h000};
  int                 n_mismatch, check_count, cycles;

  dcf_far_end far (
    .clk_i            (clk),
    .fifo_rst_n_o     (fifo_rst_n),
    .wr_clk_o         (wr_clk),
    .wr_en_first_n_o  (wr_en1_n),
    .wr_second_o      (wr_second),
    .wr_data_o        (wr_data),
    .rd_clk_o         (rd_clk),
    .rd_en_first_n_o  (rd_en1_n),
    .rd_en_second_n_o (rd_en2_n)
  );

  dcf_channel dut (
    .CORE_CLK_I             (clk),
    .SYS_RST_I              (sys_rst),
    .FIFO_RST_N_I           (fifo_rst_n),
    .WR_CLK_I               (wr_clk),
    .WR_EN_FIRST_N_I        (wr_en1_n),
    .WR_EN_SECOND_OR_LOAD_I (wr_second),
    .WR_DATA_I              (wr_data),
    .RD_CLK_I               (rd_clk),
    .RD_EN_FIRST_N_I        (rd_en1_n),
    .RD_EN_SECOND_N_I       (rd_en2_n),
    .OUT_DRIVE_N_I          (out_drive_n),
    .RD_DATA_O              (q),
    .RD_DATA_OE_O           (q_oe),
    .EMPTY_FLAG_N_O         (ef_n),
    .FULL_FLAG_N_O          (ff_n),
    .ALMOST_EMPTY_FLAG_N_O  (pae_n),
    .ALMOST_FULL_FLAG_N_O   (paf_n)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // read-side flags move only on read edges, so give a few cycles of crossing first
  task tick_rd;
    repeat (4) @(posedge clk);
    far.pop(1'b1);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    sys_rst = 1'b1;
    out_drive_n = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    far.chan_reset(1'b1);
    check("ef_n", ef_n, 9'h000);
    check("pae_n", pae_n, 9'h000);
    check("ff_n", ff_n, 9'h001);
    check("paf_n", paf_n, 9'h001);
    check("q", q, 9'h000);
    check("oe", q_oe, 9'h000);
    @(posedge clk);
    out_drive_n <= 1'b0;
    @(posedge clk);
    #1;
    check("oe", q_oe, 9'h001);
    $display("test reset done");

    far.push(9'h155, 1'b0, 1'b1);
    far.pop(1'b0);
    check("ef_n", ef_n, 9'h000);
    check("q", q, 9'h000);
    repeat (3) @(posedge clk);
    far.pop(1'b0);
    check("ef_n", ef_n, 9'h001);
    check("q", q, 9'h000);
    far.pop(1'b0);
    check("q", q, 9'h155);
    check("ef_n", ef_n, 9'h000);
    $display("test latency done");

    far.push(9'h0AA, 1'b0, 1'b0);
    for (int i = 1; i <= 7; i++) far.push(9'(i), 1'b0, 1'b1);
    tick_rd();
    check("pae_n", pae_n, 9'h000);
    far.push(9'h008, 1'b0, 1'b1);
    tick_rd();
    check("pae_n", pae_n, 9'h001);
    far.pop_split(1'b0, 1'b1);
    check("q", q, 9'h155);
    far.pop_split(1'b1, 1'b0);
    check("q", q, 9'h155);
    for (int i = 1; i <= 8; i++) begin
      far.pop(1'b0);
      check("q", q, 9'(i));
    end
    $display("test almost empty done");

    far.chan_reset(1'b1);
    for (int i = 1; i <= 256; i++) begin
      far.push(9'(i), 1'b0, 1'b1);
      check("paf_n", paf_n, 9'(i < 249));
      check("ff_n", ff_n, 9'(i < 256));
    end
    far.push(9'h1FF, 1'b0, 1'b1);
    tick_rd();
    for (int i = 1; i <= 256; i++) begin
      far.pop(1'b0);
      check("q", q, 9'(i));
    end
    check("ef_n", ef_n, 9'h000);
    far.pop(1'b0);
    check("q", q, 9'h100);
    check("ff_n", ff_n, 9'h000);
    repeat (4) @(posedge clk);
    far.push(9'h000, 1'b1, 1'b1);
    check("ff_n", ff_n, 9'h001);
    check("paf_n", paf_n, 9'h001);
    $display("test full done");

    far.chan_reset(1'b0);
    for (int k = 0; k < 4; k++) far.push(ofs[k], 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      far.pop(1'b0);
      check("ofs", q, ofs[k]);
    end
    far.push(9'h011, 1'b0, 1'b1);
    far.push(9'h022, 1'b0, 1'b1);
    tick_rd();
    check("pae_n", pae_n, 9'h000);
    far.push(9'h033, 1'b0, 1'b1);
    tick_rd();
    check("pae_n", pae_n, 9'h001);
    $display("test load mode done");
    close_out();
  end
endmodule // dcf_channel_tb_top
